// ---- src/msst_alu.sv ----
// Purpose: arithmetic and logic result for one instruction
// Assumes: purely combinational, operands valid in the execute cycle

`timescale 1ns/1ps
`default_nettype none

module msst_alu (
  input  wire msst_pkg::msst_op_t    op,
  input  wire logic [7:0]            acc,
  input  wire logic [7:0]            mem,
  input  wire logic [7:0]            imm,
  input  wire msst_pkg::msst_flags_t flags_in,
  output logic [7:0]                 result,
  output msst_pkg::msst_flags_t      flags_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // a + ~b + 1 with carry out, nibble carry and signed overflow
  function automatic logic [11:0] sub_calc(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] sum;
    logic [4:0] low;
    logic       ovf;
    sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
    low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    ovf = (a[7] == ~b[7]) && (sum[7] != a[7]);
    sub_calc = {ovf, (sum[7:0] == 8'h00), low[4], sum[8], sum[7:0]};
  endfunction

  wire logic [7:0]  sub_b    = (op == msst_pkg::op_sub_imm) ? imm : mem;
  wire logic [11:0] sub_out  = sub_calc(acc, sub_b);
  wire logic [7:0]  xor_b    = (op == msst_pkg::op_xor_imm) ? imm : mem;
  wire logic [7:0]  xor_out  = acc ^ xor_b;
  wire logic [7:0]  swap_out = {mem[3:0], mem[7:4]};
  wire logic        is_sub   = (op == msst_pkg::op_sub_to_acc) || (op == msst_pkg::op_minus_result_to_mem) ||
                               (op == msst_pkg::op_sub_imm);
  wire logic        is_xor   = (op == msst_pkg::op_xor_to_acc) || (op == msst_pkg::op_exclusive_or_to_mem) ||
                               (op == msst_pkg::op_xor_imm);

  // result and flag selection
  always_comb begin
    result    = mem;
    flags_out = flags_in;
    if (is_sub) begin
      result    = sub_out[7:0];
      flags_out = '{ov: sub_out[11], z: sub_out[10], ac: sub_out[9], c: sub_out[8]};
    end else if (is_xor) begin
      result      = xor_out;
      flags_out.z = (xor_out == 8'h00);
    end else if ((op == msst_pkg::op_swap_in_mem) || (op == msst_pkg::op_nibble_exchange_to_acc)) begin
      result = swap_out;
    end
  end

endmodule

`default_nettype wire

// ---- src/msst_apb.sv ----
// Purpose: APB slave decode and read data for the execution slice registers
// Assumes: zero wait states, pready always high
// Notes:   unmapped addresses answer pslverr and read zero, writes to them are dropped

`timescale 1ns/1ps
`default_nettype none

module msst_apb (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] rd_ctrl,
  input  wire logic [31:0] rd_acc,
  input  wire logic [31:0] rd_flags,
  input  wire logic [31:0] rd_ptr,
  input  wire logic [31:0] rd_high,
  input  wire logic [31:0] rd_status,
  output logic             wr_ctrl,
  output logic             wr_acc,
  output logic             wr_flags,
  output logic             wr_ptr,
  output logic             wr_high
);

  // address decode
  wire logic hit_ctrl   = (paddr == msst_pkg::ADDR_CTRL);
  wire logic hit_acc    = (paddr == msst_pkg::ADDR_ACC);
  wire logic hit_flags  = (paddr == msst_pkg::ADDR_FLAGS);
  wire logic hit_ptr    = (paddr == msst_pkg::ADDR_PTR);
  wire logic hit_high   = (paddr == msst_pkg::ADDR_HIGH);
  wire logic hit_status = (paddr == msst_pkg::ADDR_STATUS);
  wire logic hit_any    = hit_ctrl | hit_acc | hit_flags | hit_ptr | hit_high | hit_status;
  wire logic access     = psel & penable;
  wire logic wr_access  = access & pwrite;

  // write strobes in the access phase
  assign wr_ctrl  = wr_access & hit_ctrl;
  assign wr_acc   = wr_access & hit_acc;
  assign wr_flags = wr_access & hit_flags;
  assign wr_ptr   = wr_access & hit_ptr;
  assign wr_high  = wr_access & hit_high;
  assign pready   = 1'b1;
  assign pslverr  = access & ~hit_any;

  // read mux
  wire logic [31:0] rd_mux = hit_ctrl   ? rd_ctrl   :
                             hit_acc    ? rd_acc    :
                             hit_flags  ? rd_flags  :
                             hit_ptr    ? rd_ptr    :
                             hit_high   ? rd_high   :
                             hit_status ? rd_status : 32'h0000_0000;

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule

`default_nettype wire

// ---- src/msst_core.sv ----
// Purpose: executes subtract, nibble swap, zero skip, table read and xor instructions
// Assumes: decode stage supplies the operand byte with the instruction; rom data is valid in the same cycle as the request
// Notes:   direct memory writes and rom requests appear one cycle after the instruction is taken, table writes one cycle later
//
// The register offsets and the APB interface to the registers were decided locally.

`timescale 1ns/1ps
`default_nettype none

module msst_core (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // instruction from decode
  input  wire logic                  instr_valid,
  input  wire msst_pkg::msst_instr_t instr,
  output logic                       instr_ready,
  input  wire logic [3:0]            pc_page,
  // data memory write
  output msst_pkg::msst_mem_wr_t     mem_wr,
  // program rom
  output msst_pkg::msst_rom_req_t    rom_req,
  input  wire logic [14:0]           rom_data,
  // fetch path
  output logic                       discard_next
);

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    st_run,
    st_dummy,
    st_table
  } msst_state_t;

  msst_state_t           state;
  msst_state_t           next_state;
  logic                  enable;
  logic [7:0]            acc;
  msst_pkg::msst_flags_t flags;
  logic [7:0]            ptr;
  logic [7:0]            high_latch;
  logic [7:0]            table_dest;
  logic                  last_skip;

  // apb strobes
  logic                  wr_ctrl;
  logic                  wr_acc;
  logic                  wr_flags;
  logic                  wr_ptr;
  logic                  wr_high;

  // alu outputs
  logic [7:0]            alu_result;
  msst_pkg::msst_flags_t alu_flags;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  wire logic [31:0] rd_ctrl   = {31'h0000_0000, enable};
  wire logic [31:0] rd_acc    = {24'h00_0000, acc};
  wire logic [31:0] rd_flags  = {28'h000_0000, flags};
  wire logic [31:0] rd_ptr    = {24'h00_0000, ptr};
  wire logic [31:0] rd_high   = {24'h00_0000, high_latch};
  wire logic [31:0] rd_status = {29'h0000_0000, (state == st_table), last_skip, (state != st_run)};

  msst_apb u_apb (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .rd_ctrl   (rd_ctrl),
    .rd_acc    (rd_acc),
    .rd_flags  (rd_flags),
    .rd_ptr    (rd_ptr),
    .rd_high   (rd_high),
    .rd_status (rd_status),
    .wr_ctrl   (wr_ctrl),
    .wr_acc    (wr_acc),
    .wr_flags  (wr_flags),
    .wr_ptr    (wr_ptr),
    .wr_high   (wr_high)
  );

  // ----------------------------------------------------------------
  // execute decode
  // ----------------------------------------------------------------
  msst_alu u_alu (
    .op        (instr.op),
    .acc       (acc),
    .mem       (instr.mem_data),
    .imm       (instr.imm),
    .flags_in  (flags),
    .result    (alu_result),
    .flags_out (alu_flags)
  );

  // instruction taken only when enabled and not in a second cycle
  assign instr_ready = enable && (state == st_run);
  wire logic take = instr_valid && instr_ready;

  // destination classes
  wire logic to_acc   = (instr.op == msst_pkg::op_sub_to_acc) || (instr.op == msst_pkg::op_sub_imm) ||
                        (instr.op == msst_pkg::op_nibble_exchange_to_acc) ||
                        (instr.op == msst_pkg::op_xor_to_acc) || (instr.op == msst_pkg::op_xor_imm);
  wire logic to_mem   = (instr.op == msst_pkg::op_minus_result_to_mem) || (instr.op == msst_pkg::op_swap_in_mem) ||
                        (instr.op == msst_pkg::op_exclusive_or_to_mem);
  wire logic flag_upd = (instr.op == msst_pkg::op_sub_to_acc) || (instr.op == msst_pkg::op_sub_imm) ||
                        (instr.op == msst_pkg::op_minus_result_to_mem) || (instr.op == msst_pkg::op_xor_to_acc) ||
                        (instr.op == msst_pkg::op_xor_imm) || (instr.op == msst_pkg::op_exclusive_or_to_mem);
  wire logic is_table = (instr.op == msst_pkg::op_rom_fetch_current_page) ||
                        (instr.op == msst_pkg::op_rom_fetch_last_page);

  // skip conditions
  // zero byte and clear bit skips
  wire logic byte_zero = (instr.mem_data == 8'h00);
  wire logic bit_zero  = ~instr.mem_data[instr.bit_sel];
  wire logic skip      = ((instr.op == msst_pkg::op_test_zero_then_skip) && byte_zero) ||
                         ((instr.op == msst_pkg::op_move_test_zero_then_skip) && byte_zero) ||
                         ((instr.op == msst_pkg::op_bit_zero_then_skip) && bit_zero);

  // rom address: current page or the last page above the pointer
  // page select
  wire logic [3:0]  rom_page = (instr.op == msst_pkg::op_rom_fetch_last_page) ? msst_pkg::LAST_PAGE : pc_page;
  wire logic [11:0] rom_addr = {rom_page, ptr};

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // one or two machine cycles
  always_comb begin
    next_state = state;
    case (state)
      st_run: begin
        if (take && skip) begin
          next_state = st_dummy;
        end else if (take && is_table) begin
          next_state = st_table;
        end
      end
      st_dummy: begin
        next_state = st_run;
      end
      st_table: begin
        next_state = st_run;
      end
      default: begin
        next_state = st_run;
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_run;
    end else begin
      state <= next_state;
    end
  end

  // control enable from software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= msst_pkg::RESET_EN;
    end else if (wr_ctrl) begin
      enable <= pwdata[msst_pkg::CTRL_ENABLE_BIT];
    end
  end

  // accumulator, core update wins over a bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= msst_pkg::RESET_ACC;
    end else if (take && to_acc) begin
      acc <= alu_result;
    end else if (take && (instr.op == msst_pkg::op_move_test_zero_then_skip)) begin
      acc <= instr.mem_data;
    end else if (wr_acc) begin
      acc <= pwdata[7:0];
    end
  end

  // status flags, core update wins over a bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else if (take && flag_upd) begin
      flags <= alu_flags;
    end else if (wr_flags) begin
      flags <= pwdata[3:0];
    end
  end

  // table pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr <= msst_pkg::RESET_PTR;
    end else if (wr_ptr) begin
      ptr <= pwdata[7:0];
    end
  end

  // high-byte latch filled in the second table cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_latch <= msst_pkg::RESET_HIGH;
    end else if (state == st_table) begin
      high_latch <= {1'b0, rom_data[14:8]};
    end else if (wr_high) begin
      high_latch <= pwdata[7:0];
    end
  end

  // rom request and table destination
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_req    <= '0;
      table_dest <= 8'h00;
    end else begin
      rom_req.en <= take && is_table;
      if (take && is_table) begin
        rom_req.addr <= rom_addr;
        table_dest   <= instr.mem_addr;
      end
    end
  end

  // data memory write port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_wr <= '0;
    end else if (state == st_table) begin
      mem_wr <= '{en: 1'b1, addr: table_dest, data: rom_data[7:0]};
    end else if (take && to_mem) begin
      mem_wr <= '{en: 1'b1, addr: instr.mem_addr, data: alu_result};
    end else begin
      mem_wr.en <= 1'b0;
    end
  end

  // discard pulse to fetch and last skip status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      discard_next <= 1'b0;
      last_skip    <= 1'b0;
    end else begin
      discard_next <= take && skip;
      if (take) begin
        last_skip <= skip;
      end
    end
  end

endmodule

`default_nettype wire

// ---- src/msst_pkg.sv ----
// Purpose: shared constants and types for the subtract, swap, skip, table read and xor execution slice
// Assumes: one clock pclk at 20 MHz, asynchronous active-low reset presetn
// Notes:   register offsets are byte addresses on a 32-bit APB

package msst_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_ACC    = 8'h04;
  localparam logic [7:0] ADDR_FLAGS  = 8'h08;
  localparam logic [7:0] ADDR_PTR    = 8'h0c;
  localparam logic [7:0] ADDR_HIGH   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int FLAG_C_BIT      = 0;
  localparam int FLAG_AC_BIT     = 1;
  localparam int FLAG_Z_BIT      = 2;
  localparam int FLAG_OV_BIT     = 3;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_SKIP_BIT   = 1;
  localparam int STAT_TABLE_BIT  = 2;

  // reset values
  localparam logic [7:0] RESET_ACC   = 8'h00;
  localparam logic [7:0] RESET_PTR   = 8'h00;
  localparam logic [7:0] RESET_HIGH  = 8'h00;
  localparam logic       RESET_EN    = 1'b0;

  // rom geometry: 4 page bits above an 8-bit pointer, 15-bit words
  localparam logic [3:0] LAST_PAGE   = 4'hf;
  localparam int         ROM_AW      = 12;
  localparam int         ROM_DW      = 15;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    op_none,
    op_sub_to_acc,
    op_minus_result_to_mem,
    op_sub_imm,
    op_swap_in_mem,
    op_nibble_exchange_to_acc,
    op_test_zero_then_skip,
    op_move_test_zero_then_skip,
    op_bit_zero_then_skip,
    op_rom_fetch_current_page,
    op_rom_fetch_last_page,
    op_xor_to_acc,
    op_exclusive_or_to_mem,
    op_xor_imm
  } msst_op_t;

  typedef struct packed {
    msst_op_t   op;
    logic [7:0] mem_addr;
    logic [2:0] bit_sel;
    logic [7:0] imm;
    logic [7:0] mem_data;
  } msst_instr_t;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } msst_flags_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } msst_mem_wr_t;

  typedef struct packed {
    logic              en;
    logic [ROM_AW-1:0] addr;
  } msst_rom_req_t;

endpackage

// ---- testbench/msst_core_chk.sv ----
// Purpose: port assertions for msst_core
// Assumes: one clock pclk, presetn async active low
// Notes:   bound to every msst_core instance below
`timescale 1ns/1ps
`default_nettype none
module msst_core_chk (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    instr_valid,
  input wire msst_pkg::msst_instr_t   instr,
  input wire logic                    instr_ready,
  input wire logic [3:0]              pc_page,
  input wire msst_pkg::msst_mem_wr_t  mem_wr,
  input wire msst_pkg::msst_rom_req_t rom_req,
  input wire logic [14:0]             rom_data,
  input wire logic                    discard_next
);
  // ----------------------------------------------------------------
  // instruction take and checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // one instruction accepted at this edge
  sequence s_take(msst_pkg::msst_op_t o);
    instr_valid && instr_ready && instr.op == o;
  endsequence

  a_zero_skip: assert property (s_take(msst_pkg::op_test_zero_then_skip) ##0 instr.mem_data == 8'h00
    |=> discard_next && !instr_ready ##1 !discard_next) else $error("zero byte did not skip");
  a_nonzero_run: assert property (s_take(msst_pkg::op_test_zero_then_skip) ##0 instr.mem_data != 8'h00
    |=> !discard_next) else $error("nonzero byte skipped");
  a_move_skip: assert property (s_take(msst_pkg::op_move_test_zero_then_skip) ##0 instr.mem_data == 8'h00
    |=> discard_next) else $error("move of zero did not skip");
  a_bit_skip: assert property (s_take(msst_pkg::op_bit_zero_then_skip) ##0 !instr.mem_data[instr.bit_sel]
    |=> discard_next) else $error("clear bit did not skip");
  a_bit_run: assert property (s_take(msst_pkg::op_bit_zero_then_skip) ##0 instr.mem_data[instr.bit_sel]
    |=> !discard_next) else $error("set bit skipped");
  a_swap_write: assert property (s_take(msst_pkg::op_swap_in_mem) |=> mem_wr.en
    && mem_wr.data == {$past(instr.mem_data[3:0]), $past(instr.mem_data[7:4])}) else $error("swap write wrong");
  a_page_current: assert property (s_take(msst_pkg::op_rom_fetch_current_page)
    |=> rom_req.en && !instr_ready && rom_req.addr[11:8] == $past(pc_page)) else $error("current page fetch wrong");
  a_page_last: assert property (s_take(msst_pkg::op_rom_fetch_last_page)
    |=> rom_req.en && rom_req.addr[11:8] == msst_pkg::LAST_PAGE) else $error("last page fetch wrong");
  a_table_write: assert property (rom_req.en |=> mem_wr.en && !rom_req.en
    && mem_wr.data == $past(rom_data[7:0])) else $error("table low byte not written");
  a_xor_mem: assert property (s_take(msst_pkg::op_exclusive_or_to_mem)
    |=> mem_wr.en && mem_wr.addr == $past(instr.mem_addr)) else $error("xor memory write missing");
  a_acc_only: assert property (s_take(msst_pkg::op_nibble_exchange_to_acc)
    |=> !mem_wr.en) else $error("swap to acc wrote memory");
endmodule
bind msst_core msst_core_chk msst_core_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .instr_valid, .instr, .instr_ready, .pc_page, .mem_wr, .rom_req, .rom_data,
  .discard_next);
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for msst_core
// Assumes: registers over apb, rom answered by the bench
// Notes:   one task per scenario
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                    instr_valid, instr_ready, discard_next, obs_dis, obs_rdy, slv;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata, rdv;
  logic [3:0]              pc_page;
  logic [14:0]             rom_data, word;
  msst_pkg::msst_instr_t   instr;
  msst_pkg::msst_mem_wr_t  mem_wr, obs_wr;
  msst_pkg::msst_rom_req_t rom_req;
  int                      err_count = 0;
  int                      total_checks = 0;

  // rom answer, inverted outside a request
  assign word = {3'h5, rom_req.addr} ^ 15'h00a5;
  assign rom_data = rom_req.en ? word : ~word;

  msst_core msst_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .pc_page(pc_page),
    .mem_wr(mem_wr), .rom_req(rom_req), .rom_data(rom_data), .discard_next(discard_next));

  // 50 ns clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t mismatch got %h exp %h", $time, g, e);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one apb transfer, read data in rdv
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer, only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // offer one instruction, sample outputs in the cycle after take
  task automatic issue(input msst_pkg::msst_op_t o, input logic [7:0] ma, input logic [2:0] bs,
                       input logic [7:0] im, input logic [7:0] md);
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr <= '{o, ma, bs, im, md};
    #1;
    while (instr_ready !== 1'b1) begin
      @(posedge pclk);
      #1;
    end
    @(posedge pclk);
    instr_valid <= 1'b0;
    #1;
    obs_wr = mem_wr;
    obs_dis = discard_next;
    obs_rdy = instr_ready;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_sub;
    logic [7:0]  va [5] = '{8'h50, 8'h30, 8'h80, 8'h7f, 8'h12};
    logic [7:0]  vb [5] = '{8'h30, 8'h50, 8'h01, 8'h7f, 8'h03};
    // worked by hand: {ov, z, ac, c, result} of va - vb
    logic [11:0] ex [5] = '{12'h320, 12'h2e0, 12'h97f, 12'h700, 12'h10f};
    logic [11:0] e;
    for (int i = 0; i < 5; i++) begin
      e = ex[i];
      apb(1'b1, msst_pkg::ADDR_ACC, va[i]);
      apb(1'b1, msst_pkg::ADDR_FLAGS, 8'h00);
      issue(msst_pkg::op_sub_to_acc, 8'h21, 3'h0, 8'h00, vb[i]);
      apb(1'b0, msst_pkg::ADDR_ACC, 8'h00);
      chk(rdv, 32'(e[7:0]));
      apb(1'b0, msst_pkg::ADDR_FLAGS, 8'h00);
      chk(rdv, 32'(e[11:8]));
      apb(1'b1, msst_pkg::ADDR_ACC, va[i]);
      apb(1'b1, msst_pkg::ADDR_FLAGS, 8'h00);
      issue(msst_pkg::op_sub_imm, 8'h22, 3'h0, vb[i], 8'h00);
      apb(1'b0, msst_pkg::ADDR_ACC, 8'h00);
      chk(rdv, 32'(e[7:0]));
      apb(1'b0, msst_pkg::ADDR_FLAGS, 8'h00);
      chk(rdv, 32'(e[11:8]));
      apb(1'b1, msst_pkg::ADDR_ACC, va[i]);
      apb(1'b1, msst_pkg::ADDR_FLAGS, 8'h00);
      issue(msst_pkg::op_minus_result_to_mem, 8'h33, 3'h0, 8'h00, vb[i]);
      chk(32'(obs_wr), 32'({1'b1, 8'h33, e[7:0]}));
      apb(1'b0, msst_pkg::ADDR_FLAGS, 8'h00);
      chk(rdv, 32'(e[11:8]));
    end
  endtask

  task automatic t_swap;
    apb(1'b1, msst_pkg::ADDR_FLAGS, 8'h0f);
    issue(msst_pkg::op_swap_in_mem, 8'h40, 3'h0, 8'h00, 8'h3c);
    chk(32'(obs_wr), 32'({1'b1, 8'h40, 8'hc3}));
    issue(msst_pkg::op_nibble_exchange_to_acc, 8'h41, 3'h0, 8'h00, 8'ha5);
    chk(32'(obs_wr.en), 32'h0);
    apb(1'b0, msst_pkg::ADDR_ACC, 8'h00);
    chk(rdv, 32'h5a);
    apb(1'b0, msst_pkg::ADDR_FLAGS, 8'h00);
    chk(rdv, 32'h0f);
  endtask

  task automatic t_skip;
    msst_pkg::msst_op_t ops [6] = '{msst_pkg::op_test_zero_then_skip, msst_pkg::op_test_zero_then_skip,
      msst_pkg::op_move_test_zero_then_skip, msst_pkg::op_move_test_zero_then_skip,
      msst_pkg::op_bit_zero_then_skip, msst_pkg::op_bit_zero_then_skip};
    logic [7:0] md [6] = '{8'h00, 8'h01, 8'h00, 8'h80, 8'hfb, 8'h04};
    logic       sk [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, msst_pkg::ADDR_FLAGS, 8'h05);
      issue(ops[i], 8'h48, 3'h2, 8'h00, md[i]);
      chk(32'(obs_dis), 32'(sk[i]));
      chk(32'(obs_rdy), 32'(!sk[i]));
      apb(1'b0, msst_pkg::ADDR_FLAGS, 8'h00);
      chk(rdv, 32'h05);
      if (i == 2 || i == 3) begin
        apb(1'b0, msst_pkg::ADDR_ACC, 8'h00);
        chk(rdv, 32'(md[i]));
      end
    end
  endtask

  task automatic t_table;
    logic [14:0] w;
    apb(1'b1, msst_pkg::ADDR_PTR, 8'h9c);
    apb(1'b1, msst_pkg::ADDR_FLAGS, 8'h0a);
    for (int i = 0; i < 2; i++) begin
      w = {3'h5, (i == 0) ? 4'h6 : msst_pkg::LAST_PAGE, 8'h9c} ^ 15'h00a5;
      issue(i == 0 ? msst_pkg::op_rom_fetch_current_page : msst_pkg::op_rom_fetch_last_page,
            8'h50, 3'h0, 8'h00, 8'h00);
      chk(32'(obs_rdy), 32'h0);
      @(posedge pclk);
      #1;
      chk(32'(mem_wr), 32'({1'b1, 8'h50, w[7:0]}));
      apb(1'b0, msst_pkg::ADDR_HIGH, 8'h00);
      chk(rdv, 32'({1'b0, w[14:8]}));
      apb(1'b0, msst_pkg::ADDR_FLAGS, 8'h00);
      chk(rdv, 32'h0a);
    end
  endtask

  task automatic t_xor;
    apb(1'b1, msst_pkg::ADDR_ACC, 8'h5a);
    apb(1'b1, msst_pkg::ADDR_FLAGS, 8'h0b);
    issue(msst_pkg::op_xor_to_acc, 8'h60, 3'h0, 8'h00, 8'h5a);
    apb(1'b0, msst_pkg::ADDR_FLAGS, 8'h00);
    chk(rdv, 32'h0f);
    issue(msst_pkg::op_xor_imm, 8'h60, 3'h0, 8'h0f, 8'h00);
    apb(1'b0, msst_pkg::ADDR_ACC, 8'h00);
    chk(rdv, 32'h0f);
    issue(msst_pkg::op_exclusive_or_to_mem, 8'h61, 3'h0, 8'h00, 8'hf0);
    chk(32'(obs_wr), 32'({1'b1, 8'h61, 8'hff}));
    apb(1'b0, msst_pkg::ADDR_FLAGS, 8'h00);
    chk(rdv, 32'h0b);
    apb(1'b0, 8'h18, 8'h00);
    chk({rdv[30:0], slv}, 32'h1);
  endtask

  // hang guard
  initial begin
    #400000;
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    close_out;
  end

  // reset, enable, scenarios
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    instr_valid = 1'b0;
    instr = '0;
    pc_page = 4'h6;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, msst_pkg::ADDR_CTRL, 8'h01);
    t_sub;
    t_swap;
    t_skip;
    t_table;
    t_xor;
    close_out;
  end
endmodule
`default_nettype wire
